// ==== bench/pmsr_host.sv ====
// Bus host model that drives management bus frames bit by bit.
`timescale 1ns/10ps
module pmsr_host (
    // Clock
    input  wire clock,
    // Bus lines
    input  wire sda,
    output reg  scl,
    output reg  sda_pull
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task ph(input int n);
        repeat (n) @(negedge clock);
    endtask
    // Data moves only mid low phase, away from clock edges, so the
    // slave never mistakes a data change for a start or a stop.
    task start;
        ph(2);
        sda_pull = 1'b0;
        ph(3);
        scl = 1'b1;
        ph(5);
        sda_pull = 1'b1;
        ph(5);
        scl = 1'b0;
    endtask
    task stop;
        ph(2);
        sda_pull = 1'b1;
        ph(3);
        scl = 1'b1;
        ph(5);
        sda_pull = 1'b0;
        ph(10);
    endtask
    // Nine bits, msb first; the last one is the acknowledge slot.
    task xb(input [8:0] d, output [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            ph(2);
            sda_pull = !d[i];
            ph(3);
            scl = 1'b1;
            ph(5);
            r[i] = sda;
            scl = 1'b0;
        end
    endtask
endmodule // pmsr_host

// ==== bench/pmsr_regs_asserts.sv ====
// Concurrent checks on the ports of the power module register block.
`timescale 1ns/10ps
module pmsr_regs_asserts (
    // Clock and reset
    input logic       clock,
    input logic       reset_n,
    // Bus pins
    input logic       scl_in,
    input logic       sda_in,
    input logic       sda_out,
    input logic       sda_oe_n,
    input logic       alert_out,
    input logic       alert_oe_n,
    // Module side
    input logic       on_off_pin,
    input logic       ot_fault,
    input logic       ot_warning,
    input logic       output_enable,
    input logic [3:0] margin_ctrl
);
    logic [3:0] since_stop_q;
    logic       scl_q;
    logic       sda_q;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // Counts cycles since a stop was seen on the raw pins.
    always_ff @(posedge clock) begin
        scl_q <= scl_in;
        sda_q <= sda_in;
        if (!reset_n || (scl_in && scl_q && sda_in && !sda_q))
            since_stop_q <= 4'h0;
        else if (since_stop_q != 4'hf)
            since_stop_q <= since_stop_q + 4'h1;
    end
    sequence s_start;
        scl_in && $past(scl_in) && $fell(sda_in);
    endsequence
    property p_rst_vals;
        $rose(reset_n) |-> !output_enable && margin_ctrl == 4'h0
            && alert_oe_n && sda_oe_n;
    endproperty
    a_rst_vals: assert property (p_rst_vals)
        else $error("outputs not at reset values");
    property p_ot_fault;
        ot_fault |=> !alert_oe_n;
    endproperty
    a_ot_fault: assert property (p_ot_fault)
        else $error("fault input did not raise alert");
    property p_ot_warn;
        ot_warning |=> !alert_oe_n;
    endproperty
    a_ot_warn: assert property (p_ot_warn)
        else $error("warning input did not raise alert");
    // A slow stop detector still has to clear within a dozen cycles.
    property p_clear_after_stop;
        $rose(alert_oe_n) |-> since_stop_q <= 4'd12;
    endproperty
    a_clear_after_stop: assert property (p_clear_after_stop)
        else $error("alert released away from a stop");
    property p_alert_held;
        !alert_oe_n && !scl_in |=> !alert_oe_n;
    endproperty
    a_alert_held: assert property (p_alert_held)
        else $error("alert released inside a frame");
    property p_margin_quiet;
        s_start |=> $stable(margin_ctrl) [*3];
    endproperty
    a_margin_quiet: assert property (p_margin_quiet)
        else $error("margin changed at a start");
    property p_margin_at_stop;
        !$stable(margin_ctrl) |-> since_stop_q <= 4'd8;
    endproperty
    a_margin_at_stop: assert property (p_margin_at_stop)
        else $error("margin changed away from a stop");
    property p_od_pins;
        sda_out == 1'b0 && alert_out == 1'b0;
    endproperty
    a_od_pins: assert property (p_od_pins)
        else $error("open drain pin driven high");
endmodule // pmsr_regs_asserts
bind pmsr_regs pmsr_regs_asserts u_chk (.clock(clock), .reset_n(reset_n),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .alert_out(alert_out), .alert_oe_n(alert_oe_n),
    .on_off_pin(on_off_pin), .ot_fault(ot_fault), .ot_warning(ot_warning),
    .output_enable(output_enable), .margin_ctrl(margin_ctrl));

// ==== bench/tb_top.sv ====
// Self-checking bench for the power module register block.
`timescale 1ns/10ps
`include "pmsr_consts.vh"
module tb_top;
    logic        clock, reset_n, on_off_pin, ot_fault, ot_warning;
    wire         scl, pull, sda_out, sda_oe_n, alert_out, alert_oe_n;
    wire         output_enable;
    wire  [3:0]  margin_ctrl;
    wire         sda = !pull && (sda_oe_n || sda_out);
    int          n_mismatch, n_tests, k;
    logic [7:0]  ctl, cfg, c, d, p;
    logic [15:0] v;
    logic [7:0]  rc [0:3] = '{`PMSR_CMD_OUT_CTRL, `PMSR_CMD_ONOFF_CFG,
                              `PMSR_CMD_TEMP_STAT, `PMSR_CMD_COMM_STAT};
    logic [7:0]  re [0:3] = '{8'h00, 8'h17, 8'h00, 8'h00};
    logic [7:0]  ce [0:3] = '{8'h20, 8'h40, 8'h80, 8'h02};
    logic [7:0]  cn [0:2] = '{8'h00, 8'h10, 8'hff};
    pmsr_host host (.clock(clock), .sda(sda), .scl(scl), .sda_pull(pull));
    // Identity fields handed to the block; the values are arbitrary.
    localparam [5:0] ID_TYPE = 6'h19;
    localparam [5:0] ID_REV  = 6'h0B;
    localparam [1:0] ID_MFR  = 2'h1;
    pmsr_regs #(.MODULE_TYPE(ID_TYPE), .MODULE_REV(ID_REV),
        .MFR_ID(ID_MFR)) dut (.clock(clock), .reset_n(reset_n), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .alert_out(alert_out), .alert_oe_n(alert_oe_n),
        .on_off_pin(on_off_pin), .ot_fault(ot_fault),
        .ot_warning(ot_warning), .output_enable(output_enable),
        .margin_ctrl(margin_ctrl));
    initial clock = 1'b0;
    always #4 clock = ~clock;
    function automatic [15:0] lin(input int e, input int m);
        return {e[4:0], m[10:0]};
    endfunction
    function automatic [7:0] upd(input [7:0] o, input [7:0] w, m);
        return (o & ~m) | (w & m);
    endfunction
    function automatic logic en_exp(input [7:0] r, input [7:0] f, input q);
        return !f[4] || ((f[3] || f[2]) && (!f[3] || r[7])
            && (!f[2] || q == f[1]));
    endfunction
    function automatic [7:0] crc8(input [7:0] a, input [7:0] b);
        logic [7:0] x;
        x = a ^ b;
        for (int i = 0; i < 8; i++)
            x = {x[6:0], 1'b0} ^ (x[7] ? 8'h07 : 8'h00);
        return x;
    endfunction
    task chk(input [15:0] seen, input [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task hd(input [7:0] cm);
        logic [8:0] r;
        host.start();
        host.xb({`PMSR_BUS_ADDR, 1'b0, 1'b1}, r);
        host.xb({cm, 1'b1}, r);
    endtask
    task frm(input [7:0] cm, input int n, input [15:0] w);
        logic [8:0] r;
        hd(cm);
        for (int i = 0; i < n; i++)
            host.xb({w[8*i+:8], 1'b1}, r);
        host.stop();
    endtask
    // Words come low byte first; the closing code byte is not acked.
    task rd(input [7:0] cm, input int n, output [15:0] w);
        logic [8:0] r;
        w = 16'h0000;
        hd(cm);
        host.start();
        host.xb({`PMSR_BUS_ADDR, 1'b1, 1'b1}, r);
        for (int i = 0; i < n; i++) begin
            host.xb({8'hff, 1'b0}, r);
            w[8*i+:8] = r[8:1];
        end
        host.xb({8'hff, 1'b1}, r);
        host.stop();
    endtask
    task stop_test;
        $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #600000;
        chk(16'h0001, 16'h0000);
        stop_test;
    end
    initial begin
        reset_n = 1'b0;
        on_off_pin = 1'b1;
        ot_fault = 1'b0;
        ot_warning = 1'b0;
        ctl = 8'h00;
        cfg = 8'h17;
        k = $urandom(57042);
        repeat (5) @(negedge clock);
        reset_n = 1'b1;
        host.ph(8);
        v = 16'(en_exp(ctl, cfg, on_off_pin));
        chk(16'(output_enable), v);
        for (k = 0; k < 4; k++) begin
            rd(rc[k], 1, v);
            chk(v, 16'(re[k]));
        end
        rd(`PMSR_CMD_VIN_MIN, 2, v);
        chk(v, lin(-2, 12));
        rd(`PMSR_CMD_VOUT_MIN, 2, v);
        chk(v, lin(-10, 614));
        rd(`PMSR_CMD_MODULE_ID, 2, v);
        chk(v, {ID_REV, ID_MFR, ID_TYPE, 2'h2});
        $display("test reset and fixed words done");
        ot_warning = 1'b1;
        @(negedge clock);
        ot_warning = 1'b0;
        rd(`PMSR_CMD_TEMP_STAT, 1, v);
        chk(v, 16'h0040);
        chk(16'(alert_oe_n), 16'h0000);
        ot_fault = 1'b1;
        @(negedge clock);
        ot_fault = 1'b0;
        rd(`PMSR_CMD_TEMP_STAT, 1, v);
        chk(v, 16'h00c0);
        frm(`PMSR_CMD_CLEAR, 0, 16'h0000);
        rd(`PMSR_CMD_TEMP_STAT, 1, v);
        chk(v, 16'h0000);
        chk(16'(alert_oe_n), 16'h0001);
        $display("test temperature done");
        // Corners first: always on, nothing selected, every source.
        for (k = 0; k < 12; k++) begin
            on_off_pin = $urandom;
            d = (k < 3) ? cn[k] : $urandom;
            c = (k < 3 || $urandom % 2) ? 8'h02 : 8'h01;
            p = crc8(crc8(crc8(8'h00, 8'h50), c), d);
            frm(c, 1 + k % 2, {p, d});
            if (c == `PMSR_CMD_OUT_CTRL)
                ctl = upd(ctl, d, `PMSR_OPR_WR_MASK);
            else
                cfg = upd(cfg, d, `PMSR_CFG_WR_MASK);
            v = 16'(en_exp(ctl, cfg, on_off_pin));
            chk(16'(output_enable), v);
            chk(16'(margin_ctrl), 16'(ctl[5:2]));
            rd(`PMSR_CMD_OUT_CTRL, 1, v);
            chk(v, 16'(ctl));
            rd(`PMSR_CMD_ONOFF_CFG, 1, v);
            chk(v, 16'(cfg));
        end
        $display("test random writes done");
        for (k = 0; k < 4; k++) begin
            p = crc8(crc8(crc8(8'h00, 8'h50), 8'h01), 8'h80);
            case (k)
            0: frm(`PMSR_CMD_OUT_CTRL, 2, {~p, 8'h80});
            1: frm(`PMSR_CMD_TEMP_STAT, 1, 16'h0011);
            2: begin
                rd(8'h55, 1, v);
                chk(v, 16'h00ff);
            end
            default: frm(`PMSR_CMD_OUT_CTRL, 0, 16'h0000);
            endcase
            rd(`PMSR_CMD_COMM_STAT, 1, v);
            chk(v, 16'(ce[k]));
            chk(16'(alert_oe_n), 16'h0000);
            rd(`PMSR_CMD_OUT_CTRL, 1, v);
            chk(v, 16'(ctl));
            frm(`PMSR_CMD_CLEAR, 0, 16'h0000);
        end
        rd(`PMSR_CMD_COMM_STAT, 1, v);
        chk(v, 16'h0000);
        $display("test communication faults done");
        stop_test;
    end
endmodule // tb_top

// ==== logic/pmsr_regs.v ====
// Bus-reachable status and control registers of the power module.
`timescale 1ns/10ps
`include "pmsr_consts.vh"
// Notes on behaviour
// - Fault status bits read one when active.
// - Temperature byte: fault bit 7, warning bit 6.
// - Comm byte: bad command bit 7, bad data bit 6, other bit 1.
// - Failed packet error check sets comm bit 5.
// - Minimum input voltage word: exponent -2, mantissa 12.
// - Minimum output voltage word: exponent -10, mantissa 614.
// - Identity word: type, revision and manufacturer fields.
// - On/off configuration picks pin, command or both.
// - Configuration bits 4:1 writable, default 0x17.
// - Clear command zeroes faults and releases alert.
module pmsr_regs #(
    parameter [5:0] MODULE_TYPE = 6'h2A, // Arbitrary value.
    parameter [5:0] MODULE_REV  = 6'h05, // Arbitrary value.
    parameter [1:0] MFR_ID      = 2'h3   // Arbitrary value.
) (
    // Clock and reset
    input  wire       clock,
    input  wire       reset_n,
    // Management bus pins
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output wire       sda_oe_n,
    output wire       alert_out,
    output wire       alert_oe_n,
    // Module side
    input  wire       on_off_pin,
    input  wire       ot_fault,
    input  wire       ot_warning,
    output reg        output_enable,
    output wire [3:0] margin_ctrl
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_RX   = 2'h1;
    localparam [1:0] ST_TX   = 2'h2;

    reg       scl_m_q, scl_s_q, scl_p_q;
    reg       sda_m_q, sda_s_q, sda_p_q;
    reg       pin_m_q, pin_s_q;
    reg [1:0] state_q;
    reg [3:0] bitcnt_q;
    reg [7:0] shreg_q, cmd_q, wd0_q, last_q;
    reg [2:0] byte_idx_q, tx_idx_q;
    reg       sda_low_q, nack_q, wr_act_q;
    reg [7:0] crc_q, crc_prev_q;
    reg [7:0] opr_q, cfg_q, temp_q, comm_q;
    reg       ev_badrd_q, ev_over_q;

    wire scl_rise = scl_s_q & ~scl_p_q;
    wire scl_fall = ~scl_s_q & scl_p_q;
    wire start    = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    wire stop     = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

    function [7:0] crc8;
        input [7:0] c;
        input [7:0] b;
        integer i;
        reg [7:0] r;
        begin
            r = c ^ b;
            for (i = 0; i < 8; i = i + 1)
                r = r[7] ? ({r[6:0], 1'b0} ^ `PMSR_CRC_POLY)
                         : {r[6:0], 1'b0};
            crc8 = r;
        end
    endfunction

    // Read data and the shape of each supported command.
    reg [15:0] rd_word;
    reg [2:0]  rd_len;
    reg        sup, ro;
    reg [2:0]  exp_len;
    always @* begin
        rd_word = 16'hFFFF;
        rd_len  = 3'h0;
        sup     = 1'b1;
        ro      = 1'b1;
        exp_len = 3'h0;
        case (cmd_q)
            `PMSR_CMD_OUT_CTRL: begin
                rd_word = {8'h00, opr_q};
                rd_len  = 3'h1;
                ro      = 1'b0;
                exp_len = 3'h1;
            end
            `PMSR_CMD_ONOFF_CFG: begin
                rd_word = {8'h00, cfg_q};
                rd_len  = 3'h1;
                ro      = 1'b0;
                exp_len = 3'h1;
            end
            `PMSR_CMD_CLEAR: ro = 1'b0;
            `PMSR_CMD_TEMP_STAT: begin
                rd_word = {8'h00, temp_q};
                rd_len  = 3'h1;
            end
            `PMSR_CMD_COMM_STAT: begin
                rd_word = {8'h00, comm_q};
                rd_len  = 3'h1;
            end
            `PMSR_CMD_VIN_MIN: begin
                rd_word = `PMSR_VIN_MIN_WORD;
                rd_len  = 3'h2;
            end
            `PMSR_CMD_VOUT_MIN: begin
                rd_word = `PMSR_VOUT_MIN_WORD;
                rd_len  = 3'h2;
            end
            `PMSR_CMD_MODULE_ID: begin
                rd_word = {MODULE_REV, MFR_ID,
                           MODULE_TYPE, `PMSR_ID_LOW_FILL};
                rd_len  = 3'h2;
            end
            default: sup = 1'b0;
        endcase
    end

    // Past the data bytes the code goes out; unknown commands read ones.
    wire [7:0] tx_byte = !sup ? 8'hFF :
                         (tx_idx_q == 3'h0 && rd_len != 3'h0) ?
                         rd_word[7:0] :
                         (tx_idx_q == 3'h1 && rd_len == 3'h2) ?
                         rd_word[15:8] : crc_q;

    // Write commit decision, taken when the stop condition closes a write.
    wire [2:0] dlen = byte_idx_q - 3'h2;
    reg        do_commit;
    reg  [7:0] cset;
    always @* begin
        do_commit = 1'b0;
        cset      = 8'h00;
        if (stop && wr_act_q && byte_idx_q >= 3'h2) begin
            if (!sup)
                cset[`PMSR_COMM_BAD_CMD] = 1'b1;
            else if (ro && dlen != 3'h0)
                cset[`PMSR_COMM_BAD_DATA] = 1'b1;
            else if (dlen == exp_len)
                do_commit = 1'b1;
            else if (dlen == exp_len + 3'h1 && last_q == crc_prev_q)
                do_commit = 1'b1;
            else if (dlen == exp_len + 3'h1)
                cset[`PMSR_COMM_PEC] = 1'b1;
            else
                cset[`PMSR_COMM_OTHER] = 1'b1;
        end
        if (ev_badrd_q)
            cset[`PMSR_COMM_BAD_CMD] = 1'b1;
        if (ev_over_q)
            cset[`PMSR_COMM_OTHER] = 1'b1;
    end

    wire do_clear = do_commit && cmd_q == `PMSR_CMD_CLEAR;
    wire [7:0] tset = {ot_fault, ot_warning, 6'h00};

    // Pin and bus line synchronisers plus edge history.
    always @(posedge clock) begin
        if (!reset_n) begin
            {scl_p_q, scl_s_q, scl_m_q} <= 3'h7;
            {sda_p_q, sda_s_q, sda_m_q} <= 3'h7;
            {pin_s_q, pin_m_q}          <= 2'h0;
        end else begin
            {scl_p_q, scl_s_q, scl_m_q} <= {scl_s_q, scl_m_q, scl_in};
            {sda_p_q, sda_s_q, sda_m_q} <= {sda_s_q, sda_m_q, sda_in};
            {pin_s_q, pin_m_q}          <= {pin_m_q, on_off_pin};
        end
    end

    // Bus slave: bit timing, acknowledge and byte bookkeeping.
    always @(posedge clock) begin
        if (!reset_n) begin
            state_q    <= ST_IDLE;
            bitcnt_q   <= 4'h0;
            shreg_q    <= 8'h00;
            byte_idx_q <= 3'h0;
            tx_idx_q   <= 3'h0;
            sda_low_q  <= 1'b0;
            nack_q     <= 1'b0;
            wr_act_q   <= 1'b0;
            cmd_q      <= 8'h00;
            wd0_q      <= 8'h00;
            last_q     <= 8'h00;
            crc_q      <= 8'h00;
            crc_prev_q <= 8'h00;
            ev_badrd_q <= 1'b0;
            ev_over_q  <= 1'b0;
        end else begin
            ev_badrd_q <= 1'b0;
            ev_over_q  <= 1'b0;
            if (stop) begin
                state_q   <= ST_IDLE;
                wr_act_q  <= 1'b0;
                sda_low_q <= 1'b0;
            end else if (start) begin
                // A repeated start keeps the running code of the transfer.
                if (state_q == ST_IDLE)
                    crc_q <= 8'h00;
                state_q    <= ST_RX;
                bitcnt_q   <= 4'h0;
                byte_idx_q <= 3'h0;
                wr_act_q   <= 1'b0;
                sda_low_q  <= 1'b0;
            end else if (state_q != ST_IDLE && scl_rise) begin
                if (bitcnt_q < 4'h8 && state_q == ST_RX)
                    shreg_q <= {shreg_q[6:0], sda_s_q};
                if (bitcnt_q == 4'h8)
                    nack_q <= sda_s_q;
                bitcnt_q <= bitcnt_q + 4'h1;
            end else if (state_q != ST_IDLE && scl_fall) begin
                if (bitcnt_q == 4'h8) begin
                    sda_low_q <= 1'b0;
                    if (state_q == ST_RX) begin
                        crc_prev_q <= crc_q;
                        crc_q      <= crc8(crc_q, shreg_q);
                        if (byte_idx_q != 3'h7)
                            byte_idx_q <= byte_idx_q + 3'h1;
                        if (byte_idx_q == 3'h0) begin
                            if (shreg_q[7:1] == `PMSR_BUS_ADDR) begin
                                sda_low_q <= 1'b1;
                                if (shreg_q[0]) begin
                                    state_q    <= ST_TX;
                                    tx_idx_q   <= 3'h0;
                                    ev_badrd_q <= ~sup;
                                end else
                                    wr_act_q <= 1'b1;
                            end else
                                state_q <= ST_IDLE;
                        end else begin
                            sda_low_q <= 1'b1;
                            last_q    <= shreg_q;
                            if (byte_idx_q == 3'h1)
                                cmd_q <= shreg_q;
                            if (byte_idx_q == 3'h2)
                                wd0_q <= shreg_q;
                        end
                    end
                end else if (bitcnt_q == 4'h9) begin
                    bitcnt_q <= 4'h0;
                    if (state_q == ST_TX && !nack_q) begin
                        shreg_q   <= tx_byte;
                        sda_low_q <= ~tx_byte[7];
                        crc_q     <= crc8(crc_q, tx_byte);
                        ev_over_q <= sup & (tx_idx_q > rd_len);
                        if (tx_idx_q != 3'h7)
                            tx_idx_q <= tx_idx_q + 3'h1;
                    end else if (state_q == ST_TX) begin
                        state_q   <= ST_IDLE;
                        sda_low_q <= 1'b0;
                    end else
                        sda_low_q <= 1'b0;
                end else if (state_q == ST_TX) begin
                    shreg_q   <= {shreg_q[6:0], 1'b0};
                    sda_low_q <= ~shreg_q[6];
                end
            end
        end
    end

    // Registers, sticky status and output control.
    always @(posedge clock) begin
        if (!reset_n) begin
            opr_q         <= `PMSR_OPR_RESET;
            cfg_q         <= `PMSR_CFG_RESET;
            temp_q        <= `PMSR_STAT_RESET;
            comm_q        <= `PMSR_STAT_RESET;
            output_enable <= 1'b0;
        end else begin
            if (do_commit && cmd_q == `PMSR_CMD_OUT_CTRL)
                opr_q <= wd0_q & `PMSR_OPR_WR_MASK;
            if (do_commit && cmd_q == `PMSR_CMD_ONOFF_CFG)
                cfg_q <= (wd0_q & `PMSR_CFG_WR_MASK)
                         | `PMSR_CFG_RO_BITS;
            // A new event in the clearing cycle still lands.
            temp_q <= (do_clear ? 8'h00 : temp_q) | tset;
            comm_q <= (do_clear ? 8'h00 : comm_q) | cset;
            // Power-up bit low means the module runs whenever powered.
            if (!cfg_q[`PMSR_CFG_PU]) begin
                output_enable <= 1'b1;
            end else begin
                output_enable <=
                    (!cfg_q[`PMSR_CFG_CMD] | opr_q[`PMSR_OPR_ON]) &
                    (!cfg_q[`PMSR_CFG_PIN_EN] |
                     (cfg_q[`PMSR_CFG_POL] ? pin_s_q : ~pin_s_q)) &
                    (cfg_q[`PMSR_CFG_CMD] | cfg_q[`PMSR_CFG_PIN_EN]);
            end
        end
    end

    assign margin_ctrl = opr_q[`PMSR_OPR_MARGIN_HI:`PMSR_OPR_MARGIN_LO];
    assign sda_out     = 1'b0;
    assign sda_oe_n    = ~sda_low_q;
    // Alert follows any set status bit, so clearing them releases it.
    assign alert_out   = 1'b0;
    assign alert_oe_n  = ~(|temp_q | |comm_q);
endmodule // pmsr_regs

// ==== pkg/pmsr_consts.vh ====
// Command codes, field positions, reset values and fixed words of the block.
`ifndef PMSR_CONSTS_VH
`define PMSR_CONSTS_VH

`define PMSR_CMD_OUT_CTRL    8'h01
`define PMSR_CMD_ONOFF_CFG   8'h02
`define PMSR_CMD_CLEAR       8'h03
`define PMSR_CMD_TEMP_STAT   8'h7D
`define PMSR_CMD_COMM_STAT   8'h7E
`define PMSR_CMD_VIN_MIN     8'hA0
`define PMSR_CMD_VOUT_MIN    8'hA4
`define PMSR_CMD_MODULE_ID   8'hD0

`define PMSR_BUS_ADDR        7'h28

`define PMSR_TEMP_OT_FAULT   7
`define PMSR_TEMP_OT_WARN    6
`define PMSR_COMM_BAD_CMD    7
`define PMSR_COMM_BAD_DATA   6
`define PMSR_COMM_PEC        5
`define PMSR_COMM_OTHER      1

`define PMSR_OPR_ON          7
`define PMSR_OPR_MARGIN_HI   5
`define PMSR_OPR_MARGIN_LO   2
`define PMSR_CFG_PU          4
`define PMSR_CFG_CMD         3
`define PMSR_CFG_PIN_EN      2
`define PMSR_CFG_POL         1

`define PMSR_OPR_WR_MASK     8'hBC
`define PMSR_CFG_WR_MASK     8'h1E
`define PMSR_CFG_RO_BITS     8'h01
`define PMSR_OPR_RESET       8'h00
`define PMSR_CFG_RESET       8'h17
`define PMSR_STAT_RESET      8'h00

`define PMSR_VIN_MIN_WORD    16'hF00C
`define PMSR_VOUT_MIN_WORD   16'hB266
`define PMSR_ID_LOW_FILL     2'h2
`define PMSR_CRC_POLY        8'h07

`endif
